// *** core/smia_memory_access.sv ***
// Indirect host access to control memory and data memory of the time-slot switch.
// Assumes host strobes are one-cycle pulses from logic on the same clock.
module smia_memory_access (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   busWrite,
    input  wire logic                   busRead,
    input  wire logic [7:0]             busAddr,
    input  wire logic [7:0]             busWdata,
    output logic      [7:0]             busRdata,
    input  wire logic [1:0]             trunkMode,
    input  wire logic                   dmLoad,
    input  wire logic [6:0]             dmLoadIndex,
    input  wire logic [7:0]             dmLoadData,
    input  wire logic                   swDirection,
    input  wire logic [6:0]             swSlot,
    input  wire logic [1:0]             swPort,
    output smia_pkg::smia_slot_type     swKind,
    output logic      [7:0]             swTrunkMask,
    output logic      [7:0]             swCfiMask,
    output logic      [7:0]             swData
);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic [7:0]               opReg;
    logic [7:0]               addrReg;
    logic [7:0]               madrReg;
    logic [7:0]               subchReg;
    logic                     pendingReg;
    logic [7:0]               rdata_reg;
    logic [6:0]               fillCnt_reg;
    smia_pkg::smia_state_type stateReg;
    smia_pkg::smia_op_type    opKind;

    logic [3:0] cmCodeMem [256];
    logic [7:0] cmDataMem [256];
    logic [7:0] dmDataMem [256];
    logic [3:0] tsMem     [128];

    logic       readDir;
    logic [3:0] moc;
    logic [7:0] cmIdx;
    logic [7:0] dmIdx;
    logic [7:0] dmMask;
    logic [7:0] dmSel;
    logic [3:0] tsSel;
    logic [3:0] cmCodeSel;
    logic [7:0] cmDataSel;
    logic       execNow;
    logic       opWrite;
    logic       upstream;

    // Linear trunk index {port, slot} for each trunk mode
    function automatic logic [6:0] trunk_index(input logic [6:0] a, input logic [1:0] mode);
        logic [6:0] idx;
        idx = a;
        if (mode == 2'd0)
        begin
            idx = {a[2:1], a[6:3], a[0]};
        end
        else if (mode == 2'd1 || mode == 2'd3)
        begin
            idx = {a[2], a[6:3], a[1:0]};
        end
        return idx;
    endfunction

    assign readDir   = opReg[7];
    assign moc       = opReg[6:3];
    assign upstream  = (addrReg[smia_pkg::DIR_BIT] == smia_pkg::UPSTREAM_SEL);
    assign cmIdx     = addrReg;
    assign dmIdx     = {addrReg[7], trunk_index(addrReg[6:0], trunkMode)};
    assign dmMask    = smia_pkg::subchannel_mask(moc);
    assign dmSel     = dmDataMem[dmIdx];
    assign tsSel     = tsMem[dmIdx[6:0]];
    assign cmCodeSel = cmCodeMem[cmIdx];
    assign cmDataSel = cmDataMem[cmIdx];
    assign execNow   = (stateReg == smia_pkg::ST_EXEC);
    assign opWrite   = busWrite && busAddr == smia_pkg::OPCTL_OFFSET && !pendingReg;

    always_comb
    begin
        opKind = smia_pkg::OK_NONE;
        if (opReg[7:4] == smia_pkg::OP_CM_BOTH_HI)
        begin
            opKind = smia_pkg::OK_CM_BOTH;
        end
        else if (opReg == smia_pkg::OP_CM_CODE_RD)
        begin
            opKind = smia_pkg::OK_CM_CODE;
        end
        else if (opReg[2:0] != 3'b000)
        begin
            opKind = smia_pkg::OK_NONE;
        end
        else if (moc == smia_pkg::MOC_CM_DATA)
        begin
            opKind = smia_pkg::OK_CM_DATA;
        end
        else if (moc == smia_pkg::MOC_TS_ONE)
        begin
            opKind = smia_pkg::OK_TS_ONE;
        end
        else if (moc == smia_pkg::MOC_TS_ALL && !readDir)
        begin
            opKind = smia_pkg::OK_TS_ALL;
        end
        else if (moc[3] == 1'b0 && moc != smia_pkg::MOC_NONE)
        begin
            opKind = smia_pkg::OK_DM_DATA;
        end
    end

    // Operation register; a write while busy is dropped so the running access stays intact
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opReg <= smia_pkg::OPCTL_RESET;
        end
        else if (opWrite)
        begin
            opReg <= busWdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addrReg  <= smia_pkg::ADDR_RESET;
            subchReg <= smia_pkg::SUBCH_RESET;
        end
        else if (busWrite)
        begin
            if (busAddr == smia_pkg::ADDR_OFFSET)
            begin
                addrReg <= busWdata;
            end
            else if (busAddr == smia_pkg::SUBCH_OFFSET)
            begin
                subchReg <= busWdata;
            end
        end
    end

    // Sequencer and pending flag
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateReg    <= smia_pkg::ST_IDLE;
            pendingReg  <= 1'b0;
            fillCnt_reg <= 7'h00;
        end
        else
        begin
            case (stateReg)
                smia_pkg::ST_IDLE:
                begin
                    if (opWrite)
                    begin
                        stateReg   <= smia_pkg::ST_EXEC;
                        pendingReg <= 1'b1;
                    end
                end
                smia_pkg::ST_EXEC:
                begin
                    fillCnt_reg <= 7'h00;
                    if (opKind == smia_pkg::OK_TS_ALL)
                    begin
                        stateReg <= smia_pkg::ST_FILL;
                    end
                    else
                    begin
                        stateReg   <= smia_pkg::ST_IDLE;
                        pendingReg <= 1'b0;
                    end
                end
                smia_pkg::ST_FILL:
                begin
                    fillCnt_reg <= fillCnt_reg + 7'h01;
                    if (fillCnt_reg == smia_pkg::LAST_SLOT)
                    begin
                        stateReg   <= smia_pkg::ST_IDLE;
                        pendingReg <= 1'b0;
                    end
                end
                default:
                begin
                    stateReg   <= smia_pkg::ST_IDLE;
                    pendingReg <= 1'b0;
                end
            endcase
        end
    end

    // Data register: host writes, read operations return memory content
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            madrReg <= smia_pkg::DATA_RESET;
        end
        else if (execNow && readDir && opKind == smia_pkg::OK_DM_DATA)
        begin
            madrReg <= dmSel;
        end
        else if (execNow && readDir && opKind == smia_pkg::OK_TS_ONE)
        begin
            madrReg <= {4'h0, tsSel};
        end
        else if (execNow && readDir && opKind == smia_pkg::OK_CM_DATA)
        begin
            madrReg <= cmDataSel;
        end
        else if (execNow && opKind == smia_pkg::OK_CM_CODE)
        begin
            madrReg <= {4'h0, cmCodeSel};
        end
        else if (busWrite && busAddr == smia_pkg::DATA_OFFSET)
        begin
            madrReg <= busWdata;
        end
    end

    // Data memory data field; trunk receiver loads the downstream half
    always_ff @(posedge clock)
    begin
        if (dmLoad)
        begin
            dmDataMem[{~smia_pkg::UPSTREAM_SEL, dmLoadIndex}] <= dmLoadData;
        end
        if (execNow && !readDir && upstream && opKind == smia_pkg::OK_DM_DATA)
        begin
            dmDataMem[dmIdx] <= (dmSel & ~dmMask) | (madrReg & dmMask);
        end
    end

    // Upstream tristate field, four bits per trunk slot
    always_ff @(posedge clock)
    begin
        if (stateReg == smia_pkg::ST_FILL)
        begin
            tsMem[fillCnt_reg] <= madrReg[3:0];
        end
        else if (execNow && !readDir && opKind == smia_pkg::OK_TS_ONE)
        begin
            tsMem[dmIdx[6:0]] <= madrReg[3:0];
        end
    end

    // Control memory code and data fields
    always_ff @(posedge clock)
    begin
        if (execNow && opKind == smia_pkg::OK_CM_BOTH)
        begin
            cmCodeMem[cmIdx] <= opReg[3:0];
        end
        if (execNow && (opKind == smia_pkg::OK_CM_BOTH
                        || (opKind == smia_pkg::OK_CM_DATA && !readDir)))
        begin
            cmDataMem[cmIdx] <= madrReg;
        end
    end

    // Register read port; unmapped offsets read zero
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 8'h00;
        end
        else if (busRead)
        begin
            if (busAddr == smia_pkg::OPCTL_OFFSET)
            begin
                rdata_reg <= opReg;
            end
            else if (busAddr == smia_pkg::ADDR_OFFSET)
            begin
                rdata_reg <= addrReg;
            end
            else if (busAddr == smia_pkg::DATA_OFFSET)
            begin
                rdata_reg <= madrReg;
            end
            else if (busAddr == smia_pkg::SUBCH_OFFSET)
            begin
                rdata_reg <= subchReg;
            end
            else if (busAddr == smia_pkg::STATUS_OFFSET)
            begin
                rdata_reg <= {7'h00, pendingReg};
            end
            else
            begin
                rdata_reg <= 8'h00;
            end
        end
    end

    assign busRdata = rdata_reg;

    // Switching side: code of the slot being served
    smia_pkg::smia_slot_type swKindComb;
    logic [7:0]              swTrunkComb;
    logic [7:0]              swCfiComb;
    logic [7:0]              swIdx;
    smia_pkg::smia_slot_type swKind_reg;
    logic [7:0]              swTrunkMask_reg;
    logic [7:0]              swCfiMask_reg;
    logic [7:0]              swData_reg;

    assign swIdx = {swDirection, swSlot};

    smia_slot_decode slotDecode (
        .code      (cmCodeMem[swIdx]),
        .scBits    (subchReg[{swPort, 1'b0} +: 2]),
        .kind      (swKindComb),
        .trunkMask (swTrunkComb),
        .cfiMask   (swCfiComb)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            swKind_reg      <= smia_pkg::SK_IDLE;
            swTrunkMask_reg <= 8'h00;
            swCfiMask_reg   <= 8'h00;
            swData_reg      <= 8'h00;
        end
        else
        begin
            swKind_reg      <= swKindComb;
            swTrunkMask_reg <= swTrunkComb;
            swCfiMask_reg   <= swCfiComb;
            swData_reg      <= cmDataMem[swIdx];
        end
    end

    assign swKind      = swKind_reg;
    assign swTrunkMask = swTrunkMask_reg;
    assign swCfiMask   = swCfiMask_reg;
    assign swData      = swData_reg;

    a_pending_set: assert property (
        opWrite |=> pendingReg && stateReg == smia_pkg::ST_EXEC)
        else $error("pending flag not set by operation write");

    a_pending_short: assert property (
        execNow && opKind != smia_pkg::OK_TS_ALL |=> !pendingReg)
        else $error("pending flag not cleared after single access");

    a_fill_length: assert property (
        execNow && opKind == smia_pkg::OK_TS_ALL |-> ##128 pendingReg ##1 !pendingReg)
        else $error("broadcast tristate fill has wrong length");

    a_pending_bounded: assert property (
        $rose(pendingReg) |-> ##[1:130] !pendingReg)
        else $error("pending flag stuck");

    a_dm_read_full: assert property (
        execNow && readDir && opKind == smia_pkg::OK_DM_DATA |=> madrReg == $past(dmSel))
        else $error("data memory read not full byte");

    a_dm_write_masked: assert property (
        execNow && !readDir && upstream && opKind == smia_pkg::OK_DM_DATA
        |=> dmSel == (($past(dmSel) & ~$past(dmMask)) | ($past(madrReg) & $past(dmMask))))
        else $error("data memory subchannel write wrong");

    a_dm_down_kept: assert property (
        execNow && !readDir && !upstream && !dmLoad && opKind == smia_pkg::OK_DM_DATA
        |=> dmSel == $past(dmSel))
        else $error("downstream data memory written by host");

    a_ts_read_low: assert property (
        execNow && readDir && opKind == smia_pkg::OK_TS_ONE
        |=> madrReg == {4'h0, $past(tsSel)})
        else $error("tristate read not in low nibble");

    a_cm_both_write: assert property (
        execNow && opKind == smia_pkg::OK_CM_BOTH
        |=> cmCodeSel == $past(opReg[3:0]) && cmDataSel == $past(madrReg))
        else $error("control memory code and data write wrong");

    a_cm_data_only: assert property (
        execNow && opKind == smia_pkg::OK_CM_DATA |=> cmCodeSel == $past(cmCodeSel))
        else $error("control memory data access changed code");

    a_cm_code_read: assert property (
        execNow && opKind == smia_pkg::OK_CM_CODE |=> madrReg == {4'h0, $past(cmCodeSel)})
        else $error("control memory code read wrong");

endmodule

// *** core/smia_pkg.sv ***
// Constants, types and shared decoding for the switch memory indirect access unit.
// Assumes one 40 MHz clock and a same-clock host register port.
package smia_pkg;

    localparam logic [7:0] OPCTL_OFFSET  = 8'h00;
    localparam logic [7:0] ADDR_OFFSET   = 8'h01;
    localparam logic [7:0] DATA_OFFSET   = 8'h02;
    localparam logic [7:0] SUBCH_OFFSET  = 8'h1B;
    localparam logic [7:0] STATUS_OFFSET = 8'h1C;

    localparam logic [7:0] OPCTL_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic [7:0] SUBCH_RESET = 8'h00;

    localparam int         DIR_BIT      = 7;
    localparam logic       UPSTREAM_SEL = 1'b1;
    localparam logic [6:0] LAST_SLOT    = 7'h7F;
    localparam int         FILL_CYCLES  = 128;

    localparam logic [3:0] MOC_NONE       = 4'h0;
    localparam logic [3:0] MOC_TS_ONE     = 4'hC;
    localparam logic [3:0] MOC_TS_ALL     = 4'hD;
    localparam logic [3:0] MOC_CM_DATA    = 4'h9;
    localparam logic [3:0] OP_CM_BOTH_HI  = 4'h7;
    localparam logic [7:0] OP_CM_CODE_RD  = 8'hF0;

    localparam logic [3:0] CMC_UNASSIGNED = 4'h0;
    localparam logic [3:0] CMC_PRE_EVEN   = 4'h8;
    localparam logic [3:0] CMC_HOST       = 4'h9;
    localparam logic [3:0] CMC_PRE_A      = 4'hA;
    localparam logic [3:0] CMC_PRE_B      = 4'hB;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FILL} smia_state_type;

    typedef enum logic [2:0] {
        OK_NONE, OK_DM_DATA, OK_TS_ONE, OK_TS_ALL, OK_CM_DATA, OK_CM_BOTH, OK_CM_CODE
    } smia_op_type;

    typedef enum logic [1:0] {SK_IDLE, SK_SWITCH, SK_PREPROC, SK_HOST} smia_slot_type;

    // Trunk bits for a bandwidth code; same table for operation and slot codes
    function automatic logic [7:0] subchannel_mask(input logic [3:0] code);
        logic [7:0] m;
        m = 8'h00;
        case (code)
            4'h1:    m = 8'hFF;
            4'h3:    m = 8'hF0;
            4'h2:    m = 8'h0F;
            4'h7:    m = 8'hC0;
            4'h6:    m = 8'h30;
            4'h5:    m = 8'h0C;
            4'h4:    m = 8'h03;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

endpackage

// *** core/smia_slot_decode.sv ***
// Decodes one control memory code into slot kind and trunk and interface bit masks.
// Assumes subchannel bits already picked for the slot's logical port.
module smia_slot_decode (
    input  wire logic [3:0]          code,
    input  wire logic [1:0]          scBits,
    output smia_pkg::smia_slot_type  kind,
    output logic      [7:0]          trunkMask,
    output logic      [7:0]          cfiMask
);

    always_comb
    begin
        trunkMask = smia_pkg::subchannel_mask(code);
        cfiMask   = 8'h00;
        kind      = smia_pkg::SK_IDLE;
        if (code == smia_pkg::CMC_UNASSIGNED)
        begin
            kind = smia_pkg::SK_IDLE;
        end
        else if (code[3] == 1'b0)
        begin
            kind = smia_pkg::SK_SWITCH;
            if (trunkMask == 8'hFF)
            begin
                cfiMask = 8'hFF;
            end
            else if (code[3:1] == 3'b001)
            begin
                cfiMask = scBits[0] ? 8'h0F : 8'hF0;
            end
            else
            begin
                cfiMask = 8'hC0 >> {scBits, 1'b0};
            end
        end
        else if (code == smia_pkg::CMC_HOST)
        begin
            kind    = smia_pkg::SK_HOST;
            cfiMask = 8'hFF;
        end
        else if (code == smia_pkg::CMC_PRE_EVEN || code == smia_pkg::CMC_PRE_A
                 || code == smia_pkg::CMC_PRE_B)
        begin
            // Pair partner on the odd address may be a switching code
            kind    = smia_pkg::SK_PREPROC;
            cfiMask = 8'hFF;
        end
    end

endmodule

// *** tb/smia_host_model.sv ***
// Host processor model driving the register strobes of the memory access unit.
// Assumes a same-clock bus; every signal changes at the falling edge only.
module smia_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] busRdata,
    output logic            busWrite,
    output logic            busRead,
    output logic      [7:0] busAddr,
    output logic      [7:0] busWdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Polls that ran out of patience; the bench counts them as mismatches
    int giveUps = 0;

    initial
    begin
        busWrite = 1'b0;
        busRead  = 1'b0;
        busAddr  = 8'h00;
        busWdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        busAddr  = a;
        busWdata = d;
        busWrite = 1'b1;
        @(negedge clock);
        busWrite = 1'b0;
        // Released lines must not keep the last byte
        busWdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        busAddr = a;
        busRead = 1'b1;
        @(negedge clock);
        busRead = 1'b0;
        d       = busRdata;
    endtask

    // Bounded so a stuck flag cannot hang the host
    task automatic poll();
        logic [7:0] s;
        int         n;
        s = 8'h01;
        n = 0;
        while (s[0] !== 1'b0 && n < 300)
        begin
            rd(8'h1C, s);
            n++;
        end
        if (s[0] !== 1'b0)
        begin
            giveUps++;
        end
    endtask

    task automatic op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
        wr(8'h01, a);
        wr(8'h02, d);
        poll();
        wr(8'h00, c);
        poll();
    endtask
endmodule

// *** tb/tb_switch_memory_indirect_access.sv ***
// Self-checking bench for the switch memory indirect access unit.
// Assumes the host model above and the design's package are compiled first.
module tb_switch_memory_indirect_access;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clock = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   busWrite, busRead, dmLoad, swDirection;
    logic [7:0]             busAddr, busWdata, busRdata, dmLoadData;
    logic [7:0]             swTrunkMask, swCfiMask, swData, d, e;
    logic [6:0]             dmLoadIndex, swSlot;
    logic [1:0]             trunkMode, swPort;
    smia_pkg::smia_slot_type swKind;
    int                     err_count = 0;
    int                     n_checks = 0;
    logic [7:0]             mk [8] = '{8'hC0, 8'h30, 8'h0C, 8'h03, 8'hF0, 8'h0F, 8'hFF, 8'h00};
    logic [3:0]             cd [8] = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
    logic [7:0]             cf [8] = '{8'h00, 8'hFF, 8'hF0, 8'hF0, 8'hC0, 8'hC0, 8'hC0, 8'hC0};
    logic [1:0]             md [4] = '{2'd0, 2'd1, 2'd3, 2'd2};
    logic [7:0]             ma [4] = '{8'h06, 8'h04, 8'h0D, 8'h2A};
    logic [6:0]             mi [4] = '{7'h60, 7'h40, 7'h45, 7'h2A};
    logic [7:0]             rg [6] = '{8'h00, 8'h01, 8'h02, 8'h1B, 8'h1C, 8'h10};

    always #12.5 clock = ~clock;

    smia_host_model host (.clock, .busRdata, .busWrite, .busRead, .busAddr, .busWdata);

    smia_memory_access dut (.clock, .rst_n, .busWrite, .busRead, .busAddr, .busWdata,
        .busRdata, .trunkMode, .dmLoad, .dmLoadIndex, .dmLoadData, .swDirection, .swSlot,
        .swPort, .swKind, .swTrunkMask, .swCfiMask, .swData);

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Runs a read operation, then fetches the data register it loaded
    task automatic opRd(input logic [7:0] a, input logic [7:0] c, input logic [7:0] exp);
        logic [7:0] r;
        host.op(a, 8'h00, c);
        host.rd(8'h02, r);
        chk("data register", r, exp);
    endtask

    task automatic sw(input logic [3:0] c);
        host.op(8'h83, {4'h4, c}, {4'h7, c});
        repeat (2) @(negedge clock);
    endtask

    function automatic smia_pkg::smia_slot_type kx(input logic [3:0] c);
        if (c == 4'h0)
            return smia_pkg::SK_IDLE;
        if (c < 4'h8)
            return smia_pkg::SK_SWITCH;
        return (c == 4'h9) ? smia_pkg::SK_HOST : smia_pkg::SK_PREPROC;
    endfunction

    task automatic end_of_test();
        err_count += host.giveUps;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #(25 * 30000);
        err_count++;
        end_of_test();
    end

    initial
    begin
        trunkMode   = 2'd2;
        dmLoad      = 1'b0;
        dmLoadIndex = 7'h00;
        dmLoadData  = 8'h00;
        swDirection = 1'b1;
        swSlot      = 7'h03;
        swPort      = 2'd0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        foreach (rg[i])
        begin
            host.rd(rg[i], d);
            chk("reset value", d, 8'h00);
        end
        // Each step flips only the bits its code selects
        host.op(8'h85, 8'h00, 8'h08);
        e = 8'h00;
        foreach (cd[i])
        begin
            host.op(8'h85, ~e, {1'b0, cd[i], 3'b000});
            e = e ^ mk[i];
            opRd(8'h85, 8'h88, e);
        end
        opRd(8'h85, 8'hB8, e);
        dmLoadIndex = 7'h05;
        dmLoadData  = 8'h3C;
        dmLoad      = 1'b1;
        @(negedge clock);
        dmLoad = 1'b0;
        host.op(8'h05, 8'hC3, 8'h08);
        opRd(8'h05, 8'h88, 8'h3C);
        foreach (md[i])
        begin
            trunkMode   = md[i];
            dmLoadIndex = mi[i];
            dmLoadData  = {1'b1, mi[i]} ^ 8'h99;
            dmLoad      = 1'b1;
            @(negedge clock);
            dmLoad = 1'b0;
            opRd(ma[i], 8'h88, {1'b1, mi[i]} ^ 8'h99);
        end
        host.wr(8'h02, 8'hFA);
        host.wr(8'h00, 8'h68);
        host.rd(8'h1C, d);
        chk("pending", d, 8'h01);
        // A code read taken now would overwrite the data register
        host.wr(8'h00, 8'hF0);
        host.rd(8'h00, d);
        chk("op dropped", d, 8'h68);
        host.poll();
        host.rd(8'h1C, d);
        chk("pending", d, 8'h00);
        host.rd(8'h02, d);
        chk("data kept", d, 8'hFA);
        host.op(8'h85, 8'hF3, 8'h60);
        opRd(8'h85, 8'hE0, 8'h03);
        opRd(8'h81, 8'hE0, 8'h0A);
        host.op(8'h83, 8'h5A, 8'h71);
        opRd(8'h83, 8'hF0, 8'h01);
        opRd(8'h83, 8'hC8, 8'h5A);
        host.op(8'h83, 8'h66, 8'h48);
        opRd(8'h83, 8'hF0, 8'h01);
        opRd(8'h83, 8'hC8, 8'h66);
        host.op(8'h03, 8'h77, 8'h74);
        opRd(8'h03, 8'hF0, 8'h04);
        opRd(8'h83, 8'hF0, 8'h01);
        for (int c = 0; c < 12; c++)
        begin
            sw(c[3:0]);
            chk("slot kind", {6'h00, swKind}, {6'h00, kx(c[3:0])});
            chk("slot data", swData, {4'h4, c[3:0]});
            if (c < 8)
            begin
                chk("trunk mask", swTrunkMask, mk[7 - c]);
                chk("cfi mask", swCfiMask, cf[c]);
            end
        end
        host.wr(8'h1B, 8'h0C);
        swPort = 2'd1;
        sw(4'h4);
        chk("cfi mask", swCfiMask, 8'h03);
        sw(4'h2);
        chk("cfi mask", swCfiMask, 8'h0F);
        swDirection = 1'b0;
        repeat (2) @(negedge clock);
        chk("down trunk mask", swTrunkMask, 8'h03);
        chk("down slot data", swData, 8'h77);
        end_of_test();
    end
endmodule
